// >>> src/rnf_defines.svh
// Offsets, field positions and reset values of the receive request node filter
// Function
// R1 - The lower asynchronous filter is set by writing ones at 108h, cleared by writing ones at 10Ch, and read back at either.
// R2 - Every filter register comes out of reset as all zeros, so no node is accepted or routed.
// R3 - A request from local node 0 to 31 is accepted only when its bit in the lower asynchronous filter is one.
// R4 - The lower asynchronous filter works exactly like the upper one except for the nodes it covers.
// R5 - A request aimed at the physical context is checked again against the physical filter once the asynchronous check passes.
// R6 - With the physical filter bit of the source node at zero, the request goes to the asynchronous request context.
// R7 - The per-node physical comparison is made only for sources on the local bus.
// R8 - Packets from a nonlocal bus are not acknowledged unless bit 31 of the upper physical filter is one.
// R9 - With bit 31 of the upper physical filter at one, all asynchronous requests from nonlocal buses are accepted.
// R10 - A host bus reset keeps bit 31 of the upper physical filter and clears all its other bits.
// R11 - Bits 30 to 19 of the upper physical filter route local nodes 62 to 51 to the physical context.
// R12 - The upper physical filter is set by writing ones at 110h and reads back its value.
// R13 - Bits 18 to 0 of the upper physical filter route local nodes 50 to 32 to the physical context.
// R14 - The upper asynchronous filter sits at 100h and 104h, covers nodes 32 to 62 in bits 0 to 30, bit 31 for nonlocal buses; bit 31 unused here.
// R15 - The upper physical filter is cleared by writing ones in the word right after its set alias.
// R16 - The node number used for filtering is the six-bit physical identifier of the source identifier.
`ifndef RNF_DEFINES_SVH
`define RNF_DEFINES_SVH

`define RNF_OFS_ASYNC_HIGH_SET 12'h100
`define RNF_OFS_ASYNC_HIGH_CLR 12'h104
`define RNF_OFS_ASYNC_LOW_SET 12'h108
`define RNF_OFS_ASYNC_LOW_CLR 12'h10c
`define RNF_OFS_PHYS_HIGH_SET 12'h110
`define RNF_OFS_PHYS_HIGH_CLR 12'h114

`define RNF_FILTER_RESET 32'h0000_0000
`define RNF_PHYS_HIGH_KEEP 32'h8000_0000
`define RNF_NONLOCAL_BIT 31
`define RNF_LOCAL_BUS_ALIAS 10'h3ff
`define RNF_UNMAPPED_DATA 32'h0000_0000

`endif

// >>> src/rnf_filter_top.sv
// Receive request node filter: register bank on classic Wishbone and the per-packet decision
//
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ps
`include "rnf_defines.svh"
module rnf_filter_top
	import rnf_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_host_bus_rst,
	// Wishbone slave
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [31:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	// Local bus number of this node
	input wire logic [9:0] i_local_bus_id,
	// Received request and its decision
	input wire rnf_req_t i_req,
	output rnf_dec_t o_dec
);

	logic [31:0] async_high;
	logic [31:0] async_low;
	logic [31:0] phys_high;
	logic [31:0] lane_mask;
	logic [11:0] ofs;
	logic bus_req;
	logic wr_take;
	logic [31:0] wr_bits;
	logic [31:0] set_async_high;
	logic [31:0] clr_async_high;
	logic [31:0] set_async_low;
	logic [31:0] clr_async_low;
	logic [31:0] set_phys_high;
	logic [31:0] clr_phys_high;
	logic [31:0] next_rdata;
	logic [63:0] async_vec;
	logic [63:0] phys_vec;
	logic async_hit;
	logic phys_hit;
	logic src_local;
	logic async_ok;
	logic phys_ok;
	rnf_route_t next_route;

	// Bus access decode
	assign ofs = {i_wb_adr[11:2], 2'b00};
	assign bus_req = i_wb_cyc & i_wb_stb;

	genvar b;
	generate
		for (b = 0; b < 4; b = b + 1) begin : g_lane
			assign lane_mask[8 * b +: 8] = {8{i_wb_sel[b]}};
		end
	endgenerate

	// A write takes effect at the edge where the master sees ack
	assign wr_take = bus_req & i_wb_we & o_wb_ack;
	assign wr_bits = wr_take ? (i_wb_dat & lane_mask) : 32'h0000_0000;

	assign set_async_high = (ofs == `RNF_OFS_ASYNC_HIGH_SET) ? wr_bits : 32'h0000_0000; // R14
	assign clr_async_high = (ofs == `RNF_OFS_ASYNC_HIGH_CLR) ? wr_bits : 32'h0000_0000; // R14
	assign set_async_low = (ofs == `RNF_OFS_ASYNC_LOW_SET) ? wr_bits : 32'h0000_0000; // R1
	assign clr_async_low = (ofs == `RNF_OFS_ASYNC_LOW_CLR) ? wr_bits : 32'h0000_0000; // R1
	assign set_phys_high = (ofs == `RNF_OFS_PHYS_HIGH_SET) ? wr_bits : 32'h0000_0000; // R12
	assign clr_phys_high = (ofs == `RNF_OFS_PHYS_HIGH_CLR) ? wr_bits : 32'h0000_0000; // R15

	// Filter registers
	rnf_set_clear_reg #(
		.KEEP_MASK(`RNF_FILTER_RESET)
	) u_async_high (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_host_bus_rst(i_host_bus_rst),
		.i_set(set_async_high),
		.i_clr(clr_async_high),
		.o_value(async_high)
	);

	// Same register type as the upper filter, so both behave alike
	rnf_set_clear_reg #(
		.KEEP_MASK(`RNF_FILTER_RESET)
	) u_async_low ( // R4
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_host_bus_rst(i_host_bus_rst),
		.i_set(set_async_low),
		.i_clr(clr_async_low),
		.o_value(async_low)
	);

	rnf_set_clear_reg #(
		.KEEP_MASK(`RNF_PHYS_HIGH_KEEP)
	) u_phys_high ( // R10
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_host_bus_rst(i_host_bus_rst),
		.i_set(set_phys_high),
		.i_clr(clr_phys_high),
		.o_value(phys_high)
	);

	// Read mux; either alias of a pair returns the value
	always_comb begin
		case (ofs)
			`RNF_OFS_ASYNC_HIGH_SET, `RNF_OFS_ASYNC_HIGH_CLR: next_rdata = async_high;
			`RNF_OFS_ASYNC_LOW_SET, `RNF_OFS_ASYNC_LOW_CLR: next_rdata = async_low; // R1
			`RNF_OFS_PHYS_HIGH_SET, `RNF_OFS_PHYS_HIGH_CLR: next_rdata = phys_high; // R12
			default: next_rdata = `RNF_UNMAPPED_DATA;
		endcase
	end

	// One wait state: ack in the cycle after the request, dropped right after
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_wb_ack <= 1'b0;
		end else begin
			o_wb_ack <= bus_req & ~o_wb_ack;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_wb_dat <= 32'h0000_0000;
		end else if (bus_req & ~o_wb_ack & ~i_wb_we) begin
			o_wb_dat <= next_rdata;
		end
	end

	// Per-node vectors; node 63 is broadcast and has no bit
	assign async_vec = {1'b0, async_high[30:0], async_low}; // R3
	// Lower physical filter is outside this bank, so nodes 0 to 31 read as zero
	assign phys_vec = {1'b0, phys_high[30:0], 32'h0000_0000}; // R11 R13

	rnf_node_lookup u_async_lookup (
		.i_bits(async_vec),
		.i_node(i_req.phy_id), // R16
		.o_hit(async_hit)
	);

	rnf_node_lookup u_phys_lookup (
		.i_bits(phys_vec),
		.i_node(i_req.phy_id), // R16
		.o_hit(phys_hit)
	);

	// Decision
	assign src_local = (i_req.bus_id == `RNF_LOCAL_BUS_ALIAS) | (i_req.bus_id == i_local_bus_id);
	// Nonlocal sources hinge on the physical nonlocal bit alone
	assign async_ok = src_local ? async_hit : phys_high[`RNF_NONLOCAL_BIT]; // R3 R8 R9
	assign phys_ok = src_local & phys_hit; // R7

	always_comb begin
		if (!i_req.valid || !async_ok) begin
			next_route = RNF_DROP; // R8
		end else if (i_req.phys_dest && phys_ok) begin
			next_route = RNF_PHYS_CTX; // R5
		end else begin
			next_route = RNF_ASYNC_CTX; // R6
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_dec <= '{valid: 1'b0, is_local: 1'b0, node: 6'h00, route: RNF_DROP};
		end else begin
			o_dec.valid <= i_req.valid;
			o_dec.is_local <= src_local;
			o_dec.node <= i_req.phy_id;
			o_dec.route <= next_route;
		end
	end

	// Checks
	AST_RESET_ZERO: assert property (@(posedge i_clk) // R2
		!i_nrst |=> (async_high == 32'h0000_0000) && (async_low == 32'h0000_0000)
			&& (phys_high == 32'h0000_0000) && (o_dec.route == RNF_DROP))
		else $error("Filter registers not zero after reset");

	AST_LOW_SET: assert property (@(posedge i_clk) disable iff (!i_nrst) // R1
		(wr_take && !i_host_bus_rst && ofs == `RNF_OFS_ASYNC_LOW_SET)
			|=> async_low == ($past(async_low) | $past(i_wb_dat & lane_mask)))
		else $error("Lower async set alias did not set the written ones");

	AST_LOW_CLR: assert property (@(posedge i_clk) disable iff (!i_nrst) // R1
		(wr_take && !i_host_bus_rst && ofs == `RNF_OFS_ASYNC_LOW_CLR)
			|=> async_low == ($past(async_low) & ~$past(i_wb_dat & lane_mask)))
		else $error("Lower async clear alias did not clear the written ones");

	AST_LOW_READ: assert property (@(posedge i_clk) disable iff (!i_nrst) // R1
		(o_wb_ack && bus_req && !i_wb_we
			&& (ofs == `RNF_OFS_ASYNC_LOW_SET || ofs == `RNF_OFS_ASYNC_LOW_CLR))
			|-> o_wb_dat == $past(async_low))
		else $error("Lower async read returned a wrong value");

	AST_LOW_ACCEPT: assert property (@(posedge i_clk) disable iff (!i_nrst) // R3
		(i_req.valid && src_local && i_req.phy_id < 6'h20)
			|=> (o_dec.route != RNF_DROP) == $past(async_low[i_req.phy_id[4:0]]))
		else $error("Lower node acceptance does not follow its filter bit");

	AST_HIGH_ACCEPT: assert property (@(posedge i_clk) disable iff (!i_nrst) // R4
		(i_req.valid && src_local && i_req.phy_id >= 6'h20 && i_req.phy_id != 6'h3f)
			|=> (o_dec.route != RNF_DROP) == $past(async_high[i_req.phy_id[4:0]]))
		else $error("Upper node acceptance does not follow its filter bit");

	AST_PHYS_ROUTE: assert property (@(posedge i_clk) disable iff (!i_nrst) // R5
		(i_req.valid && i_req.phys_dest && src_local && async_hit && phys_hit)
			|=> o_dec.route == RNF_PHYS_CTX)
		else $error("Physical request with both bits set not routed to physical context");

	AST_PHYS_FALLBACK: assert property (@(posedge i_clk) disable iff (!i_nrst) // R6
		(i_req.valid && i_req.phys_dest && async_ok && !phys_ok)
			|=> o_dec.route == RNF_ASYNC_CTX)
		else $error("Physical request without its bit not sent to async context");

	AST_NONLOCAL_NO_COMPARE: assert property (@(posedge i_clk) disable iff (!i_nrst) // R7
		(i_req.valid && !src_local) |=> o_dec.route != RNF_PHYS_CTX && !o_dec.is_local)
		else $error("Nonlocal source reached the physical context");

	AST_NONLOCAL_NOACK: assert property (@(posedge i_clk) disable iff (!i_nrst) // R8
		(i_req.valid && !src_local && !phys_high[`RNF_NONLOCAL_BIT]) |=> o_dec.route == RNF_DROP)
		else $error("Nonlocal packet accepted without the nonlocal bit");

	AST_NONLOCAL_ALL: assert property (@(posedge i_clk) disable iff (!i_nrst) // R9
		(i_req.valid && !src_local && phys_high[`RNF_NONLOCAL_BIT]) |=> o_dec.route == RNF_ASYNC_CTX)
		else $error("Nonlocal packet refused with the nonlocal bit set");

	AST_HOST_KEEP: assert property (@(posedge i_clk) disable iff (!i_nrst) // R10
		i_host_bus_rst |=> phys_high == ($past(phys_high) & `RNF_PHYS_HIGH_KEEP)
			&& async_low == 32'h0000_0000 && async_high == 32'h0000_0000)
		else $error("Host bus reset did not keep only the nonlocal bit");

	AST_PHYS_BITS: assert property (@(posedge i_clk) disable iff (!i_nrst) // R11
		(i_req.valid && i_req.phys_dest && src_local && async_hit && i_req.phy_id >= 6'h20
			&& i_req.phy_id != 6'h3f && !phys_high[i_req.phy_id[4:0]])
			|=> o_dec.route == RNF_ASYNC_CTX)
		else $error("Physical routing ignored the node bit of the upper physical filter");

	AST_PHYS_SET: assert property (@(posedge i_clk) disable iff (!i_nrst) // R12
		(wr_take && !i_host_bus_rst && ofs == `RNF_OFS_PHYS_HIGH_SET)
			|=> phys_high == ($past(phys_high) | $past(i_wb_dat & lane_mask)))
		else $error("Upper physical set alias did not set the written ones");

	AST_PHYS_CLR: assert property (@(posedge i_clk) disable iff (!i_nrst) // R15
		(wr_take && !i_host_bus_rst && ofs == `RNF_OFS_PHYS_HIGH_CLR)
			|=> phys_high == ($past(phys_high) & ~$past(i_wb_dat & lane_mask)))
		else $error("Upper physical clear alias did not clear the written ones");

	AST_HIGH_SET: assert property (@(posedge i_clk) disable iff (!i_nrst) // R14
		(wr_take && !i_host_bus_rst && ofs == `RNF_OFS_ASYNC_HIGH_SET)
			|=> async_high == ($past(async_high) | $past(i_wb_dat & lane_mask)))
		else $error("Upper async set alias did not set the written ones");

	AST_NODE_ECHO: assert property (@(posedge i_clk) disable iff (!i_nrst) // R16
		i_req.valid |=> o_dec.valid && o_dec.node == $past(i_req.phy_id))
		else $error("Decision does not carry the source physical identifier");

	AST_ACK_ONE: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(bus_req && !o_wb_ack) |=> o_wb_ack ##1 !o_wb_ack)
		else $error("Bus ack not a single cycle after the request");

	AST_UNMAPPED_ZERO: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(o_wb_ack && bus_req && !i_wb_we && (ofs < `RNF_OFS_ASYNC_HIGH_SET || ofs > `RNF_OFS_PHYS_HIGH_CLR))
			|-> o_wb_dat == `RNF_UNMAPPED_DATA)
		else $error("Unmapped read did not return zero");

	AST_HIGH_CLR: assert property (@(posedge i_clk) disable iff (!i_nrst) // R14
		(wr_take && !i_host_bus_rst && ofs == `RNF_OFS_ASYNC_HIGH_CLR)
			|=> async_high == ($past(async_high) & ~$past(i_wb_dat & lane_mask)))
		else $error("Upper async clear alias did not clear the written ones");

	AST_HIGH_READ: assert property (@(posedge i_clk) disable iff (!i_nrst) // R14
		(o_wb_ack && bus_req && !i_wb_we
			&& (ofs == `RNF_OFS_ASYNC_HIGH_SET || ofs == `RNF_OFS_ASYNC_HIGH_CLR))
			|-> o_wb_dat == $past(async_high))
		else $error("Upper async read returned a wrong value");

	AST_PHYS_READ: assert property (@(posedge i_clk) disable iff (!i_nrst) // R12
		(o_wb_ack && bus_req && !i_wb_we
			&& (ofs == `RNF_OFS_PHYS_HIGH_SET || ofs == `RNF_OFS_PHYS_HIGH_CLR))
			|-> o_wb_dat == $past(phys_high))
		else $error("Upper physical read returned a wrong value");

	// Writes outside the map must not disturb any filter
	AST_UNMAPPED_WRITE: assert property (@(posedge i_clk) disable iff (!i_nrst) // R1
		(wr_take && !i_host_bus_rst && (ofs < `RNF_OFS_ASYNC_HIGH_SET || ofs > `RNF_OFS_PHYS_HIGH_CLR))
			|=> $stable(async_high) && $stable(async_low) && $stable(phys_high))
		else $error("Unmapped write changed a filter register");

	AST_HOLD_IDLE: assert property (@(posedge i_clk) disable iff (!i_nrst) // R1
		(!wr_take && !i_host_bus_rst) |=> $stable(async_high) && $stable(async_low) && $stable(phys_high))
		else $error("Filter register changed without a write or host bus reset");

	// Host bus reset wins over a write landing at the same edge
	AST_HOST_WINS: assert property (@(posedge i_clk) disable iff (!i_nrst) // R10
		(i_host_bus_rst && wr_take) |=> async_low == 32'h0000_0000 && async_high == 32'h0000_0000)
		else $error("Write survived a host bus reset at the same edge");

	AST_LOW_NO_PHYS: assert property (@(posedge i_clk) disable iff (!i_nrst) // R5
		(i_req.valid && i_req.phy_id < 6'h20) |=> o_dec.route != RNF_PHYS_CTX)
		else $error("Node below 32 reached the physical context without its filter bank");

	AST_ASYNC_DEST_NO_PHYS: assert property (@(posedge i_clk) disable iff (!i_nrst) // R5
		(i_req.valid && !i_req.phys_dest) |=> o_dec.route != RNF_PHYS_CTX)
		else $error("Request not aimed at the physical context was routed there");

	AST_BROADCAST_DROP: assert property (@(posedge i_clk) disable iff (!i_nrst) // R3
		(i_req.valid && src_local && i_req.phy_id == 6'h3f) |=> o_dec.route == RNF_DROP)
		else $error("Broadcast source was accepted");

	AST_IDLE_DROP: assert property (@(posedge i_clk) disable iff (!i_nrst)
		!i_req.valid |=> !o_dec.valid && o_dec.route == RNF_DROP)
		else $error("Decision shows a packet where none was presented");

	AST_LOCAL_FLAG: assert property (@(posedge i_clk) disable iff (!i_nrst) // R7
		i_req.valid |=> o_dec.is_local == ($past(i_req.bus_id) == `RNF_LOCAL_BUS_ALIAS
			|| $past(i_req.bus_id) == $past(i_local_bus_id)))
		else $error("Local source flag does not follow the bus number");

	AST_PHYS_LOW_BITS: assert property (@(posedge i_clk) disable iff (!i_nrst) // R13
		(i_req.valid && i_req.phys_dest && src_local && async_hit && i_req.phy_id >= 6'h20
			&& i_req.phy_id <= 6'h32 && phys_high[i_req.phy_id[4:0]])
			|=> o_dec.route == RNF_PHYS_CTX)
		else $error("Node 32 to 50 with its physical bit set not routed to physical context");

	AST_PHYS_HIGH_BITS: assert property (@(posedge i_clk) disable iff (!i_nrst) // R11
		(i_req.valid && i_req.phys_dest && src_local && async_hit && i_req.phy_id >= 6'h33
			&& i_req.phy_id <= 6'h3e && phys_high[i_req.phy_id[4:0]])
			|=> o_dec.route == RNF_PHYS_CTX)
		else $error("Node 51 to 62 with its physical bit set not routed to physical context");

	// The stored upper async bit 31 must not open the gate on its own
	AST_NONLOCAL_ASYNC_BIT: assert property (@(posedge i_clk) disable iff (!i_nrst) // R8
		(i_req.valid && !src_local && async_high[31] && !phys_high[`RNF_NONLOCAL_BIT]) |=> o_dec.route == RNF_DROP)
		else $error("Nonlocal packet accepted through the async nonlocal bit");

	AST_ACK_IDLE: assert property (@(posedge i_clk) disable iff (!i_nrst)
		!bus_req |=> !o_wb_ack)
		else $error("Bus ack without a request");

	AST_DAT_HOLD: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(bus_req && i_wb_we) |=> $stable(o_wb_dat))
		else $error("Read data changed during a write cycle");

endmodule : rnf_filter_top

// >>> src/rnf_node_lookup.sv
// Picks the filter bit of one node out of a per-node vector
`timescale 1ns/1ps
module rnf_node_lookup (
	// Per-node bits, index is the node number
	input wire logic [63:0] i_bits,
	// Node number
	input wire logic [5:0] i_node,
	// Selected bit
	output logic o_hit
);

	logic [63:0] hit_vec;

	genvar n;
	generate
		for (n = 0; n < 64; n = n + 1) begin : g_node
			assign hit_vec[n] = i_bits[n] & (i_node == 6'(n));
		end
	endgenerate

	assign o_hit = |hit_vec;

endmodule : rnf_node_lookup

// >>> src/rnf_pkg.sv
// Types shared by the receive request node filter
package rnf_pkg;

	typedef enum logic [1:0] {
		RNF_DROP,
		RNF_ASYNC_CTX,
		RNF_PHYS_CTX
	} rnf_route_t;

	typedef struct packed {
		logic valid;
		logic phys_dest;
		logic [9:0] bus_id;
		logic [5:0] phy_id;
	} rnf_req_t;

	typedef struct packed {
		logic valid;
		logic is_local;
		logic [5:0] node;
		rnf_route_t route;
	} rnf_dec_t;

endpackage : rnf_pkg

// >>> src/rnf_set_clear_reg.sv
// One 32-bit filter register with set and clear aliases
`timescale 1ns/1ps
`include "rnf_defines.svh"
module rnf_set_clear_reg #(
	parameter logic [31:0] KEEP_MASK = 32'h0000_0000
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_host_bus_rst,
	// Bit strobes
	input wire logic [31:0] i_set,
	input wire logic [31:0] i_clr,
	// Value
	output logic [31:0] o_value
);

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_value <= `RNF_FILTER_RESET; // R2
		end else if (i_host_bus_rst) begin
			// Bits in the keep mask survive a host bus reset
			o_value <= o_value & KEEP_MASK; // R10
		end else begin
			o_value <= (o_value | i_set) & ~i_clr; // R1
		end
	end

endmodule : rnf_set_clear_reg

// >>> verification/receive_request_node_filter_bench.sv
// Self-checking bench of the receive request node filter
`timescale 1ns/1ps
module receive_request_node_filter_bench
	import rnf_pkg::*;
;
	typedef struct packed {
		logic pd;
		logic [9:0] bus;
		logic [5:0] phy;
		logic loc;
		rnf_route_t route;
	} rnf_row_t;
	logic i_clk;
	logic i_nrst;
	logic i_host_bus_rst;
	logic i_wb_cyc;
	logic i_wb_stb;
	logic i_wb_we;
	logic [31:0] i_wb_adr;
	logic [3:0] i_wb_sel;
	logic [31:0] i_wb_dat;
	logic [31:0] o_wb_dat;
	logic o_wb_ack;
	logic [9:0] i_local_bus_id;
	rnf_req_t req;
	rnf_dec_t o_dec;
	int fails = 0;
	int num_checks = 0;
	// Filters: low 0x21, high 0x4008_0102, phys 0x4000_0100; node 51 and 33 lack a phys bit
	rnf_row_t rows [13] = '{
		'{1'b0, 10'h3ff, 6'd0, 1'b1, RNF_ASYNC_CTX}, '{1'b0, 10'h3ff, 6'd1, 1'b1, RNF_DROP},
		'{1'b1, 10'h3ff, 6'd5, 1'b1, RNF_ASYNC_CTX}, '{1'b0, 10'h3ff, 6'd31, 1'b1, RNF_DROP},
		'{1'b1, 10'h3ff, 6'd40, 1'b1, RNF_PHYS_CTX}, '{1'b1, 10'h3ff, 6'd62, 1'b1, RNF_PHYS_CTX},
		'{1'b1, 10'h3ff, 6'd51, 1'b1, RNF_ASYNC_CTX}, '{1'b0, 10'h3ff, 6'd40, 1'b1, RNF_ASYNC_CTX},
		'{1'b1, 10'h005, 6'd62, 1'b1, RNF_PHYS_CTX}, '{1'b1, 10'h3ff, 6'd33, 1'b1, RNF_ASYNC_CTX},
		'{1'b1, 10'h3ff, 6'd32, 1'b1, RNF_DROP}, '{1'b1, 10'h002, 6'd40, 1'b0, RNF_DROP},
		'{1'b1, 10'h3ff, 6'd63, 1'b1, RNF_DROP}};

	rnf_filter_top rnf_filter_top_inst (
		.i_clk(i_clk), .i_nrst(i_nrst), .i_host_bus_rst(i_host_bus_rst),
		.i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
		.i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
		.i_local_bus_id(i_local_bus_id), .i_req(req), .o_dec(o_dec));
	rnf_node_model rnf_node_model_inst (.i_clk(i_clk), .o_req(req));

	initial begin
		i_clk = 1'b0;
	end
	always #5 i_clk = ~i_clk;

	task automatic tally_and_finish;
		$display("checks %0d, mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : tally_and_finish

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : check

	// Classic single cycle; the request stands until ack is seen at a rising edge
	task automatic wb(input logic we, input logic [31:0] adr, input logic [3:0] sel, input logic [31:0] dat,
			output logic [31:0] rd);
		int n;
		@(posedge i_clk);
		i_wb_cyc <= 1'b1;
		i_wb_stb <= 1'b1;
		i_wb_we <= we;
		i_wb_adr <= adr;
		i_wb_sel <= sel;
		i_wb_dat <= dat;
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (o_wb_ack !== 1'b1 && n < 50);
		rd = o_wb_dat;
		if (n >= 50) begin
			fails++;
			$display("unexpected at %0t: no bus answer", $time);
		end
		i_wb_cyc <= 1'b0;
		i_wb_stb <= 1'b0;
		i_wb_we <= 1'b0;
	endtask : wb

	task automatic wr(input logic [31:0] adr, input logic [3:0] sel, input logic [31:0] dat);
		logic [31:0] rd;
		wb(1'b1, adr, sel, dat, rd);
	endtask : wr

	task automatic rdchk(input logic [31:0] adr, input logic [31:0] exp);
		logic [31:0] rd;
		wb(1'b0, adr, 4'hf, 32'h0000_0000, rd);
		check(rd, exp);
	endtask : rdchk

	task automatic pkt(input rnf_row_t r);
		rnf_node_model_inst.send(r.pd, r.bus, r.phy);
		check(32'(o_dec), 32'({1'b1, r.loc, r.phy, r.route}));
	endtask : pkt

	initial begin
		#200000;
		fails++;
		$display("unexpected at %0t: run did not end", $time);
		tally_and_finish();
	end

	initial begin
		i_nrst = 1'b0;
		i_host_bus_rst = 1'b0;
		i_wb_cyc = 1'b0;
		i_wb_stb = 1'b0;
		i_wb_we = 1'b0;
		i_wb_adr = 32'h0000_0000;
		i_wb_sel = 4'h0;
		i_wb_dat = 32'h0000_0000;
		i_local_bus_id = 10'h005;
		repeat (2) @(posedge i_clk);
		i_nrst <= 1'b1;
		for (int a = 0; a < 6; a++) begin
			rdchk(32'h0000_0100 + 32'(a * 4), 32'h0000_0000);
		end
		wr(32'h0000_0108, 4'hf, 32'h0000_0023);
		wr(32'h0000_010c, 4'hf, 32'h0000_0002);
		rdchk(32'h0000_0108, 32'h0000_0021);
		rdchk(32'h0000_010c, 32'h0000_0021);
		wr(32'h0000_0100, 4'hf, 32'h4008_0102);
		rdchk(32'h0000_0104, 32'h4008_0102);
		// Byte lanes: only the top lane is set, then the clear alias trims it
		wr(32'h0000_0110, 4'h8, 32'hffff_ffff);
		wr(32'h0000_0114, 4'hf, 32'hbf00_0000);
		wr(32'h0000_0110, 4'hf, 32'h0000_0100);
		rdchk(32'h0000_0114, 32'h4000_0100);
		wr(32'h0000_0120, 4'hf, 32'hffff_ffff);
		rdchk(32'h0000_0120, 32'h0000_0000);
		foreach (rows[i]) begin
			pkt(rows[i]);
		end
		wr(32'h0000_0110, 4'hf, 32'h8000_0000);
		pkt('{1'b1, 10'h002, 6'd40, 1'b0, RNF_ASYNC_CTX});
		@(posedge i_clk);
		i_host_bus_rst <= 1'b1;
		@(posedge i_clk);
		i_host_bus_rst <= 1'b0;
		rdchk(32'h0000_0110, 32'h8000_0000);
		rdchk(32'h0000_0108, 32'h0000_0000);
		rdchk(32'h0000_0100, 32'h0000_0000);
		pkt('{1'b0, 10'h3ff, 6'd0, 1'b1, RNF_DROP});
		pkt('{1'b1, 10'h002, 6'd40, 1'b0, RNF_ASYNC_CTX});
		// A full reset in mid-run clears the nonlocal bit as well
		@(posedge i_clk);
		i_nrst <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_nrst <= 1'b1;
		rdchk(32'h0000_0110, 32'h0000_0000);
		tally_and_finish();
	end
endmodule : receive_request_node_filter_bench

// >>> verification/rnf_node_model.sv
// Behavioural model of the remote nodes that send request packets
`timescale 1ns/1ps
module rnf_node_model
	import rnf_pkg::*;
(
	// Clock
	input wire logic i_clk,
	// Request toward the filter
	output rnf_req_t o_req
);
	initial begin
		o_req = '0;
	end
	// One packet is a one-cycle valid pulse; idle fields toggle so nothing stale looks like a packet
	task automatic send(input logic phys_dest, input logic [9:0] bus_id, input logic [5:0] phy_id);
		@(posedge i_clk);
		o_req <= '{valid: 1'b1, phys_dest: phys_dest, bus_id: bus_id, phy_id: phy_id};
		@(posedge i_clk);
		o_req <= {1'b0, ~o_req[16:0]};
		#1;
	endtask : send
endmodule : rnf_node_model
